//--- hw/wdrc_key_window.sv
// Timed-access key sequencer that opens the protected-bit write window
module wdrc_key_window
  import wdrc_pkg::*;
(
  input  wire logic       clk_in,         // Core clock
  input  wire logic       rstn_in,        // Async reset, active low
  input  wire logic       any_wr_in,      // Any accepted register write
  input  wire logic       key_wr_in,      // Accepted write to key register
  input  wire logic [7:0] key_data_in,    // Key write data
  output logic            window_out      // Protected bits writable
);
  typedef enum logic [1:0] {WDRC_KEY_IDLE, WDRC_KEY_ARMED, WDRC_KEY_OPEN} wdrc_key_t;

  wdrc_key_t  state;      // Sequencer state
  logic [3:0] win_cnt;    // Clocks left in window

  // ============================================================
  // Key sequence: AA then 55 as the very next mapped-register write
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state   <= WDRC_KEY_IDLE;
      win_cnt <= 4'h0;
    end else begin
      case (state)
        WDRC_KEY_IDLE: begin
          if (key_wr_in && key_data_in == WDRC_KEY_FIRST) begin
            state <= WDRC_KEY_ARMED;
          end
        end
        WDRC_KEY_ARMED: begin
          // Any other mapped-register write in between breaks the sequence; a repeated AA keeps it armed
          if (key_wr_in && key_data_in == WDRC_KEY_SECOND) begin
            state   <= WDRC_KEY_OPEN;
            win_cnt <= 4'(WDRC_WIN_CLKS - 1);
          end else if (key_wr_in && key_data_in == WDRC_KEY_FIRST) begin
            state <= WDRC_KEY_ARMED;
          end else if (any_wr_in) begin
            state <= WDRC_KEY_IDLE;
          end
        end
        WDRC_KEY_OPEN: begin
          // Window closes on its own after three machine cycles
          if (win_cnt == 4'h0) begin
            state <= WDRC_KEY_IDLE;
          end else begin
            win_cnt <= win_cnt - 4'h1;
          end
        end
        default: begin
          state <= WDRC_KEY_IDLE;
        end
      endcase
    end
  end

  // Handshake-style level, decoded from state
  assign window_out = (state == WDRC_KEY_OPEN);
endmodule

//--- hw/wdrc_pkg.sv
// Package of offsets, field positions, reset values and timing counts for the watchdog block
// ============================================================
// How it works
// - Power-up condition sets the power-on flag
// - Only a software write clears the power-on flag
// - Time-out sets interrupt flag when interrupt enabled
// - Time-out sets interrupt flag even when disabled
// - Watchdog reset sets the reset flag until cleared
// - Power-fail and power-on resets clear reset flag
// - Reset enable low leaves reset flag unchanged
// - Reset enable arms watchdog to reset the chip
// - Restart bit reloads counter, then clears itself
// - Time-out interrupt, then reset 512 clocks later
// - External reset loads control register pattern 0x0x0xx0
// - Power-on sets power-on flag, clears reset enable
// - All control bits readable; baud bit freely writable
// - Protected bits writable only in timed-access window
// - Enable register top three bits read one
// - Priority register holds watchdog priority at bit 4
// - One machine cycle is four core clocks
// - Window stays open three machine cycles
package wdrc_pkg;

  // ============================================================
  // Register indices and byte addresses
  localparam logic [7:0] WDRC_KEY_IDX    = 8'hc7;  // Timed-access key register
  localparam logic [7:0] WDRC_CTL_IDX    = 8'hd8;  // Watchdog control register
  localparam logic [7:0] WDRC_IEN_IDX    = 8'he8;  // Extended interrupt enable
  localparam logic [7:0] WDRC_IPR_IDX    = 8'hf8;  // Extended interrupt priority
  localparam logic [9:0] WDRC_KEY_ADDR   = {WDRC_KEY_IDX, 2'b00};
  localparam logic [9:0] WDRC_CTL_ADDR   = {WDRC_CTL_IDX, 2'b00};
  localparam logic [9:0] WDRC_IEN_ADDR   = {WDRC_IEN_IDX, 2'b00};
  localparam logic [9:0] WDRC_IPR_ADDR   = {WDRC_IPR_IDX, 2'b00};

  // ============================================================
  // Control register field positions
  localparam int WDRC_BAUD_BIT  = 7;  // Uart1 baud double
  localparam int WDRC_POR_BIT   = 6;  // Power-on flag
  localparam int WDRC_IFLG_BIT  = 3;  // Watchdog interrupt flag
  localparam int WDRC_RFLG_BIT  = 2;  // Watchdog reset flag
  localparam int WDRC_REN_BIT   = 1;  // Watchdog reset enable
  localparam int WDRC_KICK_BIT  = 0;  // Watchdog restart
  localparam int WDRC_WDI_BIT   = 4;  // Irq enable / priority bit
  localparam int WDRC_EXT_W     = 4;  // External interrupt 2..5 bits

  // ============================================================
  // Reset values
  localparam logic [2:0] WDRC_IEN_TOP   = 3'h7;  // Reserved, read high
  localparam logic [2:0] WDRC_IPR_TOP   = 3'h0;  // Reserved, read low
  localparam logic [4:0] WDRC_IRQ_RST   = 5'h00; // Enables and priorities

  // ============================================================
  // Keys and timing
  localparam logic [7:0] WDRC_KEY_FIRST  = 8'haa;
  localparam logic [7:0] WDRC_KEY_SECOND = 8'h55;
  localparam int         WDRC_MC_CLKS    = 4;
  localparam int         WDRC_WIN_MC     = 3;
  localparam int         WDRC_WIN_CLKS   = WDRC_MC_CLKS * WDRC_WIN_MC;
  localparam int         WDRC_RST_DELAY  = 512;                 // Clocks, time-out to reset
  localparam int         WDRC_TIMEOUT    = 131072;              // Default interval, clocks

endpackage

//--- hw/wdrc_timer.sv
// Watchdog interval counter with time-out and delayed chip-reset pulses
module wdrc_timer
  import wdrc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CLKS = WDRC_TIMEOUT  // Interval in clocks
)
(
  input  wire logic clk_in,       // Core clock
  input  wire logic rstn_in,      // Async reset, active low
  input  wire logic restart_in,   // Return counter to start
  input  wire logic ren_in,       // Reset enable
  output logic      timeout_out,  // One-cycle time-out pulse
  output logic      reset_out     // One-cycle watchdog reset pulse
);
  typedef enum logic {WDRC_T_RUN, WDRC_T_HOLD} wdrc_tstate_t;

  wdrc_tstate_t state;  // Counting interval or reset delay
  logic [31:0]  cnt;    // Shared clock counter

  // ============================================================
  // Interval, then 512-clock hold-off before reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state       <= WDRC_T_RUN;
      cnt         <= 32'h0;
      timeout_out <= 1'b0;
      reset_out   <= 1'b0;
    end else begin
      timeout_out <= 1'b0;
      reset_out   <= 1'b0;
      if (restart_in) begin
        state <= WDRC_T_RUN;
        cnt   <= 32'h0;
      end else begin
        case (state)
          WDRC_T_RUN: begin
            if (cnt == 32'(TIMEOUT_CLKS - 1)) begin
              timeout_out <= 1'b1;
              state       <= WDRC_T_HOLD;
              cnt         <= 32'h0;
            end else begin
              cnt <= cnt + 32'h1;
            end
          end
          WDRC_T_HOLD: begin
            if (cnt == 32'(WDRC_RST_DELAY - 1)) begin
              // Without the enable the interval simply starts over
              reset_out <= ren_in;
              state     <= WDRC_T_RUN;
              cnt       <= 32'h0;
            end else begin
              cnt <= cnt + 32'h1;
            end
          end
          default: begin
            state <= WDRC_T_RUN;
          end
        endcase
      end
    end
  end
endmodule

//--- hw/wdrc_top.sv
// Watchdog control, reset-cause flags and interrupt enable registers behind APB
module wdrc_top
  import wdrc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CLKS = wdrc_pkg::WDRC_TIMEOUT  // Watchdog interval
)
(
  input  wire logic        clk_in,                     // Core clock, 100 MHz
  input  wire logic        rstn_in,                    // Power-on reset, active low
  input  wire logic        psel_in,                    // APB select
  input  wire logic        penable_in,                 // APB enable
  input  wire logic        pwrite_in,                  // APB direction
  input  wire logic [9:0]  paddr_in,                   // APB byte address
  input  wire logic [31:0] pwdata_in,                  // APB write data
  output logic [31:0]      prdata_out,                 // APB read data
  output logic             pready_out,                 // APB ready
  output logic             pslverr_out,                // APB error
  input  wire logic        power_up_in,                // Power-up condition pin
  input  wire logic        power_fail_in,              // Power-fail reset pin
  input  wire logic        ext_reset_in,               // External reset pin
  output logic             watchdog_irq_out,           // Watchdog interrupt request
  output logic             watchdog_irq_priority_out,  // Its priority
  output logic [3:0]       ext_irq_enable_out,         // External 2..5 enables
  output logic [3:0]       ext_irq_priority_out,       // External 2..5 priorities
  output logic             uart1_baud_double_out,      // Uart1 baud doubling
  output logic             chip_reset_out              // Watchdog chip reset pulse
);
  import wdrc_pkg::*;

  // ============================================================
  // Pin synchronisers and edge detection
  logic [2:0] pin_raw;    // Raw pin levels
  logic [2:0] pin_meta;   // First stage, read only by second
  logic [2:0] pin_sync;   // Second stage
  logic [2:0] pin_prev;   // Delayed copy for edges
  logic [2:0] pin_rise;   // One-cycle rising edge

  assign pin_raw = {ext_reset_in, power_fail_in, power_up_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      // Two flops before any logic reads the pin
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
          pin_prev[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
          pin_prev[gi] <= pin_sync[gi];
        end
      end
      assign pin_rise[gi] = pin_sync[gi] & ~pin_prev[gi];
    end
  endgenerate

  logic power_up_evt;    // Power-on event
  logic power_fail_evt;  // Power-fail reset event
  logic ext_reset_evt;   // External reset event
  logic wdt_reset_evt;   // Watchdog reset from timer
  logic timeout_evt;     // Watchdog interval elapsed
  logic any_reset_evt;   // Any reset that reloads control

  assign power_up_evt   = pin_rise[0];
  assign power_fail_evt = pin_rise[1];
  assign ext_reset_evt  = pin_rise[2];
  // Every reset applies the external-reset pattern first
  assign any_reset_evt  = power_up_evt | power_fail_evt | ext_reset_evt | wdt_reset_evt;

  // ============================================================
  // APB decode
  logic       setup_ph;     // Setup cycle
  logic       wr_acc;       // Write taking effect this edge
  logic       hit_key;      // Address is key register
  logic       hit_ctl;      // Address is control register
  logic       hit_ien;      // Address is enable register
  logic       hit_ipr;      // Address is priority register
  logic       hit_any;      // Address mapped
  logic [7:0] wdata;        // Low byte of write data
  logic       window_open;  // Protected bits writable

  // Zero wait states: every access ends at its first access edge
  assign pready_out = 1'b1;
  assign setup_ph   = psel_in & ~penable_in;
  assign wr_acc     = psel_in & penable_in & pwrite_in;
  assign hit_key    = (paddr_in == WDRC_KEY_ADDR);
  assign hit_ctl    = (paddr_in == WDRC_CTL_ADDR);
  assign hit_ien    = (paddr_in == WDRC_IEN_ADDR);
  assign hit_ipr    = (paddr_in == WDRC_IPR_ADDR);
  assign hit_any    = hit_key | hit_ctl | hit_ien | hit_ipr;
  assign wdata      = pwdata_in[7:0];

  logic wr_ctl;     // Accepted control write
  logic wr_prot;    // Accepted protected-bit write
  assign wr_ctl   = wr_acc & hit_ctl;
  assign wr_prot  = wr_ctl & window_open;

  // ============================================================
  // Timed-access key window
  wdrc_key_window u_key (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .any_wr_in   (wr_acc & hit_any),
    .key_wr_in   (wr_acc & hit_key),
    .key_data_in (wdata),
    .window_out  (window_open)
  );

  // ============================================================
  // Control register bits
  logic baud_dbl;   // Uart1 baud double
  logic por_flag;   // Power-on flag
  logic irq_flag;   // Watchdog interrupt flag
  logic rst_flag;   // Watchdog reset flag
  logic rst_en;     // Watchdog reset enable
  logic restart;    // Restart bit, self-clearing

  // Baud doubling: ordinary write, cleared by any reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      baud_dbl <= 1'b0;
    end else if (any_reset_evt) begin
      baud_dbl <= 1'b0;
    end else if (wr_ctl) begin
      baud_dbl <= wdata[WDRC_BAUD_BIT];
    end
  end

  // Power-on flag: hardware sets, only software clears
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      por_flag <= 1'b1;
    end else if (power_up_evt) begin
      // Set wins over a write in the same cycle
      por_flag <= 1'b1;
    end else if (wr_prot) begin
      por_flag <= wdata[WDRC_POR_BIT];
    end
  end

  // Interrupt flag: set on time-out whatever the enable
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_flag <= 1'b0;
    end else if (timeout_evt) begin
      // A clear landing on the time-out edge loses
      irq_flag <= 1'b1;
    end else if (any_reset_evt) begin
      irq_flag <= 1'b0;
    end else if (wr_prot) begin
      irq_flag <= wdata[WDRC_IFLG_BIT];
    end
  end

  // Reset flag: cause of last reset, kept across external reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_flag <= 1'b0;
    end else if (wdt_reset_evt) begin
      // Only issued while reset enable is high
      rst_flag <= 1'b1;
    end else if (power_up_evt || power_fail_evt) begin
      rst_flag <= 1'b0;
    end else if (wr_ctl) begin
      rst_flag <= wdata[WDRC_RFLG_BIT];
    end
  end

  // Reset enable: cleared by power-on or a timed-access write
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_en <= 1'b0;
    end else if (power_up_evt) begin
      rst_en <= 1'b0;
    end else if (wr_prot) begin
      rst_en <= wdata[WDRC_REN_BIT];
    end
  end

  // Restart bit: reads one for a single cycle after a timed-access write of one
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      restart <= 1'b0;
    end else if (wr_prot && !any_reset_evt) begin
      restart <= wdata[WDRC_KICK_BIT];
    end else begin
      restart <= 1'b0;
    end
  end

  // ============================================================
  // Watchdog counter
  logic timer_restart;  // Counter back to start
  // Restart on software request and on every reset
  assign timer_restart = restart | any_reset_evt;

  wdrc_timer #(
    .TIMEOUT_CLKS (TIMEOUT_CLKS)
  ) u_timer (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .restart_in  (timer_restart),
    .ren_in      (rst_en),
    .timeout_out (timeout_evt),
    .reset_out   (wdt_reset_evt)
  );

  // ============================================================
  // Extended interrupt enable and priority
  logic       wdi_en;     // Watchdog interrupt enable
  logic [3:0] ext_en;     // External 2..5 enables
  logic       wdi_pri;    // Watchdog priority, 1 high
  logic [3:0] ext_pri;    // External 2..5 priorities

  // Enable register: low five bits writable, cleared by resets
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {wdi_en, ext_en} <= WDRC_IRQ_RST;
    end else if (any_reset_evt) begin
      {wdi_en, ext_en} <= WDRC_IRQ_RST;
    end else if (wr_acc && hit_ien) begin
      {wdi_en, ext_en} <= wdata[WDRC_WDI_BIT:0];
    end
  end

  // Priority register: bit 4 watchdog, 0 low 1 high
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {wdi_pri, ext_pri} <= WDRC_IRQ_RST;
    end else if (any_reset_evt) begin
      {wdi_pri, ext_pri} <= WDRC_IRQ_RST;
    end else if (wr_acc && hit_ipr) begin
      {wdi_pri, ext_pri} <= wdata[WDRC_WDI_BIT:0];
    end
  end

  // ============================================================
  // Read data, registered in the setup cycle
  logic [7:0] rd_byte;   // Selected register image

  // All control bits readable; reserved bits per register
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctl) begin
      rd_byte[WDRC_BAUD_BIT] = baud_dbl;
      rd_byte[WDRC_POR_BIT]  = por_flag;
      rd_byte[WDRC_IFLG_BIT] = irq_flag;
      rd_byte[WDRC_RFLG_BIT] = rst_flag;
      rd_byte[WDRC_REN_BIT]  = rst_en;
      rd_byte[WDRC_KICK_BIT] = restart;
    end else if (hit_ien) begin
      rd_byte = {WDRC_IEN_TOP, wdi_en, ext_en};
    end else if (hit_ipr) begin
      rd_byte = {WDRC_IPR_TOP, wdi_pri, ext_pri};
    end
  end

  // Capturing in setup keeps data and error on flops
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_out  <= 32'h0;
      pslverr_out <= 1'b0;
    end else if (setup_ph) begin
      prdata_out  <= pwrite_in ? 32'h0 : {24'h0, rd_byte};
      pslverr_out <= ~hit_any;
    end else if (!psel_in) begin
      pslverr_out <= 1'b0;
    end
  end

  // ============================================================
  // Outputs toward the core
  // Request gated by the enable; the flag itself is not
  assign watchdog_irq_out          = irq_flag & wdi_en;
  assign watchdog_irq_priority_out = wdi_pri;
  assign ext_irq_enable_out        = ext_en;
  assign ext_irq_priority_out      = ext_pri;
  assign uart1_baud_double_out     = baud_dbl;
  assign chip_reset_out            = wdt_reset_evt;
endmodule

//--- testbench/tb.sv
// Self-checking bench for the watchdog control block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wdrc_pkg::*;
  localparam int TO = 200;  // Shortened interval keeps the run brief
  logic        clk_in;
  logic        rstn_in;
  logic        psel_in;
  logic        penable_in;
  logic        pwrite_in;
  logic [9:0]  paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        power_up_in;
  logic        power_fail_in;
  logic        ext_reset_in;
  logic        watchdog_irq_out;
  logic        watchdog_irq_priority_out;
  logic [3:0]  ext_irq_enable_out;
  logic [3:0]  ext_irq_priority_out;
  logic        uart1_baud_double_out;
  logic        chip_reset_out;
  logic [32:0] expq[$];       // Expected {error, data} of pending reads
  logic [31:0] rnd;           // Random source state
  int          n_fail;
  int          total_checks;
  int          cyc;
  int          k;

  wdrc_top #(.TIMEOUT_CLKS(TO)) u_wdrc_top (
    .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .power_up_in(power_up_in), .power_fail_in(power_fail_in), .ext_reset_in(ext_reset_in),
    .watchdog_irq_out(watchdog_irq_out),
    .watchdog_irq_priority_out(watchdog_irq_priority_out),
    .ext_irq_enable_out(ext_irq_enable_out), .ext_irq_priority_out(ext_irq_priority_out),
    .uart1_baud_double_out(uart1_baud_double_out), .chip_reset_out(chip_reset_out));

  // ============================================================
  // Clock, hang guard and helpers
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ============================================================
  // APB master: entered just after an edge, holds until pready, one idle edge after
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    psel_in   <= 1'b1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= {24'h0, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [9:0] a, input logic e, input logic [7:0] d);
    expq.push_back({e, 24'h0, d});
    apb(1'b0, a, 8'h00);
  endtask
  // Key pair opens the protected window
  task automatic open_key();
    wr(WDRC_KEY_ADDR, WDRC_KEY_FIRST);
    wr(WDRC_KEY_ADDR, WDRC_KEY_SECOND);
  endtask
  task automatic pulse(input logic [2:0] p);
    {power_up_in, power_fail_in, ext_reset_in} <= p;
    repeat (4) @(posedge clk_in);
    {power_up_in, power_fail_in, ext_reset_in} <= 3'h0;
    repeat (6) @(posedge clk_in);
  endtask

  // Read results checked oldest first as each access phase completes
  always @(posedge clk_in) begin
    if (psel_in && penable_in && pready_out && !pwrite_in) begin
      chk("read", expq.pop_front(), {pslverr_out, prdata_out});
    end
  end

  // ============================================================
  // Main sequence
  initial begin
    {rstn_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
    {power_up_in, power_fail_in, ext_reset_in} = 3'h0;
    rnd = 32'h69d1;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    rd(WDRC_CTL_ADDR, 1'b0, 8'h40);
    rd(WDRC_IEN_ADDR, 1'b0, 8'he0);
    rd(WDRC_IPR_ADDR, 1'b0, 8'h00);
    rd(10'h004, 1'b1, 8'h00);
    wr(WDRC_CTL_ADDR, 8'hcf);
    rd(WDRC_CTL_ADDR, 1'b0, 8'hc4);
    chk("baud", 33'h1, {32'h0, uart1_baud_double_out});
    pulse(3'b001);
    rd(WDRC_CTL_ADDR, 1'b0, 8'h44);
    pulse(3'b010);
    rd(WDRC_CTL_ADDR, 1'b0, 8'h40);
    open_key();
    repeat (9) @(posedge clk_in);
    wr(WDRC_CTL_ADDR, 8'h02);
    rd(WDRC_CTL_ADDR, 1'b0, 8'h02);
    open_key();
    repeat (10) @(posedge clk_in);
    wr(WDRC_CTL_ADDR, 8'h00);
    rd(WDRC_CTL_ADDR, 1'b0, 8'h02);
    wr(WDRC_KEY_ADDR, WDRC_KEY_FIRST);
    wr(WDRC_IPR_ADDR, 8'h00);
    wr(WDRC_KEY_ADDR, WDRC_KEY_SECOND);
    wr(WDRC_CTL_ADDR, 8'h00);
    rd(WDRC_CTL_ADDR, 1'b0, 8'h02);
    for (k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      wr(WDRC_IEN_ADDR, rnd[7:0]);
      rd(WDRC_IEN_ADDR, 1'b0, {3'h7, rnd[4:0]});
      wr(WDRC_IPR_ADDR, rnd[15:8]);
      rd(WDRC_IPR_ADDR, 1'b0, {3'h0, rnd[12:8]});
      chk("enables", {29'h0, rnd[3:0]}, {29'h0, ext_irq_enable_out});
      chk("priorities", {29'h0, rnd[11:8]}, {29'h0, ext_irq_priority_out});
    end
    wr(WDRC_IEN_ADDR, 8'h10);
    open_key();
    wr(WDRC_CTL_ADDR, 8'h03);
    rd(WDRC_CTL_ADDR, 1'b0, 8'h02);
    k = 0;
    while (watchdog_irq_out !== 1'b1 && k < 400) begin
      @(negedge clk_in);
      k++;
    end
    chk("irq_delay", 33'h1, {32'h0, k >= TO - 6 && k <= TO + 4});
    k = 0;
    while (chip_reset_out !== 1'b1 && k < 600) begin
      @(negedge clk_in);
      k++;
    end
    chk("reset_delay", 33'h1, {32'h0, k >= 508 && k <= 514});
    @(posedge clk_in);
    rd(WDRC_CTL_ADDR, 1'b0, 8'h06);
    open_key();
    wr(WDRC_CTL_ADDR, 8'h00);
    repeat (250) @(posedge clk_in);
    rd(WDRC_CTL_ADDR, 1'b0, 8'h08);
    chk("irq_pin", 33'h0, {32'h0, watchdog_irq_out});
    repeat (600) @(posedge clk_in);
    rd(WDRC_CTL_ADDR, 1'b0, 8'h08);
    pulse(3'b100);
    rd(WDRC_CTL_ADDR, 1'b0, 8'h40);
    report_and_stop();
  end
endmodule

bind wdrc_top wdrc_monitor u_wdrc_monitor (
  .clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .prdata_out(prdata_out), .power_up_in(power_up_in), .power_fail_in(power_fail_in),
  .ext_reset_in(ext_reset_in), .watchdog_irq_out(watchdog_irq_out),
  .watchdog_irq_priority_out(watchdog_irq_priority_out),
  .ext_irq_enable_out(ext_irq_enable_out), .uart1_baud_double_out(uart1_baud_double_out),
  .chip_reset_out(chip_reset_out));

//--- testbench/wdrc_monitor.sv
// Port-level assertions for the watchdog control block
module wdrc_monitor
  import wdrc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [9:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [31:0] prdata_out,
  input  wire logic        power_up_in,
  input  wire logic        power_fail_in,
  input  wire logic        ext_reset_in,
  input  wire logic        watchdog_irq_out,
  input  wire logic        watchdog_irq_priority_out,
  input  wire logic [3:0]  ext_irq_enable_out,
  input  wire logic        uart1_baud_double_out,
  input  wire logic        chip_reset_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // ============================================================
  // Helpers
  logic       wr;        // Write access phase
  logic       rd_set;    // Read setup phase
  logic       irq_q;     // Request one cycle back
  logic       ien_wr_q;  // Enable written last cycle
  logic [3:0] pin_age;   // Recent reset pin activity
  logic [9:0] irq_age;   // Cycles since request rose
  assign wr     = psel_in & penable_in & pwrite_in;
  assign rd_set = psel_in & ~penable_in & ~pwrite_in;

  // Ages; a rise caused by an enable write is not a time-out, so it is not timed
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_q    <= 1'b0;
      ien_wr_q <= 1'b0;
      pin_age  <= 4'h0;
      irq_age  <= 10'h000;
    end else begin
      irq_q    <= watchdog_irq_out;
      ien_wr_q <= wr && paddr_in == WDRC_IEN_ADDR;
      if (power_up_in | power_fail_in | ext_reset_in) begin
        pin_age <= 4'h8;
      end else if (pin_age != 4'h0) begin
        pin_age <= pin_age - 4'h1;
      end
      if (!watchdog_irq_out) begin
        irq_age <= 10'h000;
      end else if (!irq_q) begin
        irq_age <= ien_wr_q ? 10'h000 : 10'h001;
      end else if (irq_age != 10'h000 && irq_age != 10'h3ff) begin
        irq_age <= irq_age + 10'h001;
      end
    end
  end

  // ============================================================
  // Assertions
  property p_ien_top;
    rd_set && paddr_in == WDRC_IEN_ADDR |=> prdata_out[7:5] == 3'h7;
  endproperty
  a_ien_top: assert property (p_ien_top) else $error("enable top bits not high");
  property p_ipr_top;
    rd_set && paddr_in == WDRC_IPR_ADDR |=> prdata_out[7:5] == 3'h0;
  endproperty
  a_ipr_top: assert property (p_ipr_top) else $error("priority top bits not low");
  property p_baud;
    wr && paddr_in == WDRC_CTL_ADDR |=> uart1_baud_double_out == $past(pwdata_in[7]);
  endproperty
  a_baud: assert property (p_baud) else $error("baud bit write lost");
  property p_prio;
    wr && paddr_in == WDRC_IPR_ADDR |=> watchdog_irq_priority_out == $past(pwdata_in[4]);
  endproperty
  a_prio: assert property (p_prio) else $error("priority bit wrong");
  property p_en;
    wr && paddr_in == WDRC_IEN_ADDR |=> ext_irq_enable_out == $past(pwdata_in[3:0]);
  endproperty
  a_en: assert property (p_en) else $error("enable bits wrong");
  property p_irq_hold;
    $fell(watchdog_irq_out) |-> $past(wr) || chip_reset_out || $past(chip_reset_out)
      || pin_age != 4'h0;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped by itself");
  property p_rst_gap;
    chip_reset_out && irq_age != 10'h000 |-> irq_age >= 10'd508 && irq_age <= 10'd514;
  endproperty
  a_rst_gap: assert property (p_rst_gap) else $error("reset not 512 after request");
  property p_pulse;
    chip_reset_out |=> !chip_reset_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("chip reset longer than a cycle");
endmodule
